// >>> dv/osc_relay_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Relay or solid-state relay outputs
// ----------------------------------------
// Each call makes n full on-then-off cycles on the outputs in mask.
// The hold time per level is an argument, so both prompt (2 cycles, the
// shortest the synchroniser accepts) and slow switching can be driven.
module osc_relay_model (
  input  wire logic       sys_clk_i,
  output logic      [1:0] ctrl_out_o
);
  initial ctrl_out_o = 2'h0;

  task automatic cycles(input int n, input int hold, input logic [1:0] mask);
    repeat (n) begin
      repeat (hold) @(posedge sys_clk_i);
      ctrl_out_o <= mask;
      repeat (hold) @(posedge sys_clk_i);
      ctrl_out_o <= 2'h0;
    end
    repeat (10) @(posedge sys_clk_i);
  endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
`include "osc_consts.svh"

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); end end

module testbench
  import osc_pkg::*;
;
  logic               sys_clk_i;
  logic               arst_n_i;
  logic [`OSC_AW-1:0] addr_i;
  logic [`OSC_DW-1:0] wr_data_i;
  logic               wr_i;
  logic               rd_i;
  logic [`OSC_DW-1:0] rd_data_o;
  logic [1:0]         ctrl_out_i;
  logic [1:0]         data_err_i;
  osc_status_s        status_i;
  logic               fkey_press_i;
  osc_disp_s          disp_o;
  logic               show_alarm1_o;
  logic               alarm_to_ctrl_o;
  logic               alarm_to_aux_o;
  logic               irq_o;
  int                 n_mismatch;
  int                 comparisons;
  logic               p;

  osc_counter_alarm #(
    .HALF_CYCLES (8),
    .HAS_HEATER  (1'b1)
  ) uut (
    .sys_clk_i       (sys_clk_i),
    .arst_n_i        (arst_n_i),
    .addr_i          (addr_i),
    .wr_data_i       (wr_data_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .rd_data_o       (rd_data_o),
    .ctrl_out_i      (ctrl_out_i),
    .data_err_i      (data_err_i),
    .status_i        (status_i),
    .fkey_press_i    (fkey_press_i),
    .disp_o          (disp_o),
    .show_alarm1_o   (show_alarm1_o),
    .alarm_to_ctrl_o (alarm_to_ctrl_o),
    .alarm_to_aux_o  (alarm_to_aux_o),
    .irq_o           (irq_o)
  );

  osc_relay_model relay (
    .sys_clk_i  (sys_clk_i),
    .ctrl_out_o (ctrl_out_i)
  );

  // ----------------------------------------
  // Clock, bus tasks, closing
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i      <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr_i      <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1;
    `CHK(rd_data_o, exp)
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    arst_n_i     = 1'b0;
    addr_i       = 8'h00;
    wr_data_i    = 32'h0;
    wr_i         = 1'b0;
    rd_i         = 1'b0;
    data_err_i   = 2'h0;
    status_i     = '0;
    fkey_press_i = 1'b0;
    n_mismatch   = 0;
    comparisons  = 0;
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    cyc(1);
    `CHK(disp_o.mon_visible, 1'b0)
    rchk(`OSC_OFS_MON1, 32'h0);
    rchk(`OSC_OFS_MON2, 32'h0);
    rchk(`OSC_OFS_LIM1, 32'h0);
    rchk(`OSC_OFS_DISP, 32'h0);
    rchk(8'h3C, 32'h0);
    $display("test reset done");

    // Out2 limit stays zero, so only out1 counts
    wr(`OSC_OFS_LIM1, 32'h1);
    wr(`OSC_OFS_CTRL, 32'h4);
    wr(`OSC_OFS_IRQ_EN, 32'h1);
    rchk(`OSC_OFS_DISP, 32'h100);
    relay.cycles(100, 3, 2'h3);
    rchk(`OSC_OFS_MON1, 32'h1);
    rchk(`OSC_OFS_MON2, 32'h0);
    `CHK(alarm_to_ctrl_o, 1'b0)
    relay.cycles(100, 2, 2'h1);
    rchk(`OSC_OFS_MON1, 32'h0001_0002);
    `CHK(irq_o, 1'b1)
    `CHK(alarm_to_ctrl_o, 1'b1)
    wr(`OSC_OFS_CTRL, 32'h8);
    cyc(2);
    `CHK(alarm_to_aux_o, 1'b1)
    `CHK(alarm_to_ctrl_o, 1'b0)
    wr(`OSC_OFS_IRQ_EN, 32'h0);
    cyc(2);
    `CHK(irq_o, 1'b0)
    rchk(`OSC_OFS_IRQ_ST, 32'h1);
    wr(`OSC_OFS_IRQ_CLR, 32'h1);
    rchk(`OSC_OFS_IRQ_ST, 32'h0);
    $display("test counting done");

    wr(`OSC_OFS_CLR, 32'h0);
    rchk(`OSC_OFS_MON1, 32'h0001_0002);
    wr(`OSC_OFS_CLR, 32'h1);
    rchk(`OSC_OFS_MON1, 32'h0);
    rchk(`OSC_OFS_CLR, 32'h0);
    wr(`OSC_OFS_CTRL, 32'h1);
    relay.cycles(100, 5, 2'h1);
    rchk(`OSC_OFS_MON1, 32'h0);
    wr(`OSC_OFS_LIM2, 32'h3FFF);
    rchk(`OSC_OFS_LIM2, 32'h270F);
    wr(`OSC_OFS_CTRL, 32'h3);
    cyc(2);
    `CHK(disp_o.mon_visible, 1'b0)
    $display("test clear and linear done");

    wr(`OSC_OFS_LIM2, 32'h5);
    @(posedge sys_clk_i);
    data_err_i <= 2'h2;
    @(posedge sys_clk_i);
    data_err_i <= 2'h0;
    cyc(4);
    rchk(`OSC_OFS_MON2, 32'h0003_270F);
    // Forced alarm is also a fresh alarm rise on out2
    rchk(`OSC_OFS_IRQ_ST, 32'hA);
    // Full scale must not wrap once counting resumes
    wr(`OSC_OFS_CTRL, 32'h0);
    relay.cycles(100, 2, 2'h2);
    rchk(`OSC_OFS_MON2, 32'h0003_270F);

    // All conditions hold, so every selected tag must appear
    @(posedge sys_clk_i);
    status_i <= '1;
    for (int c = 1; c <= 8; c++) begin
      wr(`OSC_OFS_DISP, 32'(c));
      cyc(3);
      `CHK(disp_o.d1_tag, osc_tag_e'(4'(c)))
    end
    p = disp_o.d1_phase;
    cyc(8);
    `CHK(disp_o.d1_phase, ~p)
    wr(`OSC_OFS_DISP, 32'h70);
    cyc(3);
    `CHK(disp_o.d2_src, OSC_D2_SPSTAT)
    `CHK(disp_o.d2_tag, OSC_TAG_HEATER)
    p = disp_o.d2_phase;
    cyc(8);
    `CHK(disp_o.d2_phase, ~p)
    wr(`OSC_OFS_DISP, 32'h0);
    cyc(3);
    `CHK(disp_o.d2_src, OSC_D2_PEND)
    @(posedge sys_clk_i);
    status_i.prog_end_hold <= 1'b0;
    cyc(3);
    `CHK(disp_o.d2_src, OSC_D2_AT)
    p = disp_o.d2_blank;
    cyc(8);
    `CHK(disp_o.d2_blank, ~p)
    `CHK(disp_o.d2_phase, 1'b0)
    @(posedge sys_clk_i);
    status_i.autotune <= 1'b0;
    cyc(3);
    `CHK(disp_o.d2_src, OSC_D2_COUNT)
    `CHK(disp_o.d2_tag, OSC_TAG_COUNT)
    `CHK(disp_o.d2_blank, 1'b0)
    p = disp_o.d2_phase;
    cyc(8);
    `CHK(disp_o.d2_phase, ~p)
    wr(`OSC_OFS_CLR, 32'h2);
    rchk(`OSC_OFS_MON2, 32'h0);
    $display("test error and display done");

    wr(`OSC_OFS_FKEY, 32'hF);
    @(posedge sys_clk_i);
    fkey_press_i <= 1'b1;
    @(posedge sys_clk_i);
    fkey_press_i <= 1'b0;
    cyc(2);
    `CHK(show_alarm1_o, 1'b1)
    wr(`OSC_OFS_FKEY, 32'hD);
    @(posedge sys_clk_i);
    fkey_press_i <= 1'b1;
    @(posedge sys_clk_i);
    fkey_press_i <= 1'b0;
    cyc(2);
    `CHK(show_alarm1_o, 1'b0)
    $display("test function key done");
    end_sim();
  end
endmodule

// >>> rtl/osc_consts.svh
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

`define OSC_AW          8
`define OSC_DW          32
`define OSC_CW          14
`define OSC_PW          7
`define OSC_IRQ_W       4
`define OSC_IRQ_ERR_BIT 2
`define OSC_HW          27

`define OSC_OFS_CTRL    8'h00
`define OSC_OFS_LIM1    8'h04
`define OSC_OFS_LIM2    8'h08
`define OSC_OFS_CLR     8'h0C
`define OSC_OFS_MON1    8'h10
`define OSC_OFS_MON2    8'h14
`define OSC_OFS_DISP    8'h18
`define OSC_OFS_IRQ_ST  8'h1C
`define OSC_OFS_IRQ_CLR 8'h20
`define OSC_OFS_IRQ_EN  8'h24
`define OSC_OFS_FKEY    8'h28

`define OSC_MON_MAX     14'h270F
`define OSC_LIM_OFF     14'h0000
`define OSC_PRE_LAST    7'h63
`define OSC_CLR_OUT1    2'h1
`define OSC_CLR_OUT2    2'h2
`define OSC_ROUTE_CTRL  2'h1
`define OSC_ROUTE_AUX   2'h2
`define OSC_ITEM_AL1    5'h07

`define OSC_CLK_MHZ     250
`define OSC_HALF_MS     500
`define OSC_HALF_CYC    (`OSC_HALF_MS * `OSC_CLK_MHZ * 1000)

`endif

// >>> rtl/osc_counter_alarm.sv
`timescale 1ns/1ps
`include "osc_consts.svh"

module osc_counter_alarm
  import osc_pkg::*;
#(
  parameter int       HALF_CYCLES = `OSC_HALF_CYC,
  parameter bit       HAS_HEATER  = 1'b1
) (
  input  wire logic               sys_clk_i,
  input  wire logic               arst_n_i,
  input  wire logic [`OSC_AW-1:0] addr_i,
  input  wire logic [`OSC_DW-1:0] wr_data_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [`OSC_DW-1:0] rd_data_o,
  input  wire logic [1:0]         ctrl_out_i,
  input  wire logic [1:0]         data_err_i,
  input  wire osc_status_s        status_i,
  input  wire logic               fkey_press_i,
  output osc_disp_s               disp_o,
  output logic                    show_alarm1_o,
  output logic                    alarm_to_ctrl_o,
  output logic                    alarm_to_aux_o,
  output logic                    irq_o
);

  osc_state_s s;
  osc_state_s next_s;
  logic       pv_hit;
  logic       sp_hit;
  logic [1:0] clr_hit;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic tag_cond(osc_tag_e sel, osc_status_s st,
                                    logic heater_ok);
    logic hit;
    hit = 1'b0;
    case (sel)
      OSC_TAG_MANUAL:  hit = st.manual;
      OSC_TAG_RESET:   hit = st.reset_st;
      OSC_TAG_ALARM1:  hit = st.alarm[0];
      OSC_TAG_ALARM2:  hit = st.alarm[1];
      OSC_TAG_ALARM3:  hit = st.alarm[2];
      OSC_TAG_ANY:     hit = |st.alarm;
      OSC_TAG_HEATER:  hit = heater_ok & (st.burnout | st.short_al | st.overcur);
      OSC_TAG_STANDBY: hit = st.standby;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [`OSC_CW-1:0] lim_clamp(logic [`OSC_DW-1:0] v);
    logic [`OSC_CW-1:0] r;
    r = v[`OSC_CW-1:0];
    if (v > {{(`OSC_DW-`OSC_CW){1'b0}}, `OSC_MON_MAX}) begin
      r = `OSC_MON_MAX;
    end
    return r;
  endfunction

  assign pv_hit = tag_cond(s.pv_sel, status_i, HAS_HEATER);
  assign sp_hit = tag_cond(s.sp_sel, status_i, HAS_HEATER);

  // Clear select is a command, not stored: it reads back as zero
  assign clr_hit[0] = wr_i && (addr_i == `OSC_OFS_CLR)
                      && (wr_data_i[1:0] == `OSC_CLR_OUT1);
  assign clr_hit[1] = wr_i && (addr_i == `OSC_OFS_CLR)
                      && (wr_data_i[1:0] == `OSC_CLR_OUT2);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0]            agree;
    logic [1:0]            off_edge;
    logic [`OSC_IRQ_W-1:0] ev;
    osc_ctrl_reg_s         ctrl_w;
    osc_disp_reg_s         disp_w;
    osc_fkey_reg_s         fkey_w;
    osc_mon_reg_s          mon_r;
    osc_ctrl_reg_s         ctrl_r;
    osc_disp_reg_s         disp_r;
    osc_fkey_reg_s         fkey_r;
    agree    = '0;
    off_edge = '0;
    ev       = '0;
    ctrl_w   = osc_ctrl_reg_s'(wr_data_i);
    disp_w   = osc_disp_reg_s'(wr_data_i);
    fkey_w   = osc_fkey_reg_s'(wr_data_i);
    mon_r    = '0;
    ctrl_r   = '0;
    disp_r   = '0;
    fkey_r   = '0;
    next_s   = s;
    next_s.rdata = '0;

    // Three-stage pin synchroniser; only stages 2 and 3 are compared
    next_s.sync1 = ctrl_out_i;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;

    for (int i = 0; i < 2; i++) begin
      agree[i] = (s.sync2[i] == s.sync3[i]);
      if (agree[i]) begin
        next_s.level[i] = s.sync3[i];
      end
      // One full on-then-off cycle completes at the off edge
      off_edge[i] = s.level[i] && agree[i] && !s.sync3[i];
      if (off_edge[i] && !s.lin[i] && (s.lim[i] != `OSC_LIM_OFF)) begin
        if (s.pre[i] == `OSC_PRE_LAST) begin
          next_s.pre[i] = '0;
          if (s.mon[i] != `OSC_MON_MAX) begin
            next_s.mon[i] = s.mon[i] + `OSC_CW'(1);
          end
        end else begin
          next_s.pre[i] = s.pre[i] + `OSC_PW'(1);
        end
      end
      if (clr_hit[i]) begin
        next_s.pre[i] = '0;
        next_s.mon[i] = '0;
        next_s.err[i] = 1'b0;
      end
      // A corruption report in the clear cycle still wins
      if (data_err_i[i]) begin
        next_s.mon[i] = `OSC_MON_MAX;
        next_s.err[i] = 1'b1;
        ev[`OSC_IRQ_ERR_BIT+i] = 1'b1;
      end
      next_s.alarm[i] = (s.lim[i] != `OSC_LIM_OFF)
                        && (s.err[i] || (s.mon[i] > s.lim[i]));
      ev[i] = next_s.alarm[i] && !s.alarm[i];
    end

    // Register writes
    if (wr_i) begin
      case (addr_i)
        `OSC_OFS_CTRL: begin
          next_s.lin   = ctrl_w.linear;
          next_s.route = ctrl_w.route;
        end
        `OSC_OFS_LIM1: begin
          next_s.lim[0] = lim_clamp(wr_data_i);
        end
        `OSC_OFS_LIM2: begin
          next_s.lim[1] = lim_clamp(wr_data_i);
        end
        `OSC_OFS_DISP: begin
          next_s.pv_sel = disp_w.pv_sel;
          next_s.sp_sel = disp_w.sp_sel;
        end
        `OSC_OFS_IRQ_EN: begin
          next_s.irq_en = wr_data_i[`OSC_IRQ_W-1:0];
        end
        `OSC_OFS_FKEY: begin
          next_s.fkey_mode = fkey_w.mode;
          next_s.fkey_item = fkey_w.item;
        end
        default: begin
        end
      endcase
    end

    // Sticky status: a new event beats a simultaneous clear
    if (wr_i && (addr_i == `OSC_OFS_IRQ_CLR)) begin
      next_s.irq_st = (s.irq_st & ~wr_data_i[`OSC_IRQ_W-1:0]) | ev;
    end else begin
      next_s.irq_st = s.irq_st | ev;
    end

    // Register reads, data valid in the following cycle
    if (rd_i) begin
      case (addr_i)
        `OSC_OFS_CTRL: begin
          ctrl_r.linear = s.lin;
          ctrl_r.route  = s.route;
          next_s.rdata  = ctrl_r;
        end
        `OSC_OFS_LIM1:   next_s.rdata = `OSC_DW'(s.lim[0]);
        `OSC_OFS_LIM2:   next_s.rdata = `OSC_DW'(s.lim[1]);
        `OSC_OFS_MON1: begin
          mon_r.count  = s.mon[0];
          mon_r.alarm  = s.alarm[0];
          mon_r.err    = s.err[0];
          next_s.rdata = mon_r;
        end
        `OSC_OFS_MON2: begin
          mon_r.count  = s.mon[1];
          mon_r.alarm  = s.alarm[1];
          mon_r.err    = s.err[1];
          next_s.rdata = mon_r;
        end
        `OSC_OFS_DISP: begin
          disp_r.pv_sel  = s.pv_sel;
          disp_r.sp_sel  = s.sp_sel;
          disp_r.visible = s.disp.mon_visible;
          next_s.rdata   = disp_r;
        end
        `OSC_OFS_IRQ_ST: next_s.rdata = `OSC_DW'(s.irq_st);
        `OSC_OFS_IRQ_EN: next_s.rdata = `OSC_DW'(s.irq_en);
        `OSC_OFS_FKEY: begin
          fkey_r.mode    = s.fkey_mode;
          fkey_r.item    = s.fkey_item;
          fkey_r.showing = s.show_al1;
          next_s.rdata   = fkey_r;
        end
        default:         next_s.rdata = '0;
      endcase
    end

    // Half-second alternation beat
    if (s.half_cnt == `OSC_HW'(HALF_CYCLES - 1)) begin
      next_s.half_cnt = '0;
      next_s.phase    = !s.phase;
    end else begin
      next_s.half_cnt = s.half_cnt + `OSC_HW'(1);
    end

    // A key press opens the alarm value view when mode is set and the item is alarm 1, and closes it otherwise
    if (fkey_press_i) begin
      next_s.show_al1 = s.fkey_mode && (s.fkey_item == `OSC_ITEM_AL1);
    end

    // First display
    next_s.disp.d1_phase = pv_hit && s.phase;
    next_s.disp.d1_tag   = pv_hit ? s.pv_sel : OSC_TAG_OFF;

    // Second display, fixed priority
    next_s.disp.d2_blank = 1'b0;
    next_s.disp.d2_phase = 1'b0;
    next_s.disp.d2_tag   = OSC_TAG_OFF;
    if (sp_hit) begin
      next_s.disp.d2_src   = OSC_D2_SPSTAT;
      next_s.disp.d2_tag   = s.sp_sel;
      next_s.disp.d2_phase = s.phase;
    end else if (status_i.prog_end_hold) begin
      next_s.disp.d2_src   = OSC_D2_PEND;
      next_s.disp.d2_tag   = OSC_TAG_PEND;
      next_s.disp.d2_phase = s.phase;
    end else if (status_i.autotune) begin
      next_s.disp.d2_src   = OSC_D2_AT;
      next_s.disp.d2_tag   = OSC_TAG_AT;
      next_s.disp.d2_blank = s.phase;
    end else if (|s.alarm) begin
      next_s.disp.d2_src   = OSC_D2_COUNT;
      next_s.disp.d2_tag   = OSC_TAG_COUNT;
      next_s.disp.d2_phase = s.phase;
    end else begin
      next_s.disp.d2_src   = OSC_D2_VALUE;
    end

    next_s.disp.mon_visible = !(&s.lin)
      && !((s.lim[0] == `OSC_LIM_OFF) && (s.lim[1] == `OSC_LIM_OFF));
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      s.disp.d2_src <= OSC_D2_VALUE;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o       = s.rdata;
  assign disp_o          = s.disp;
  assign show_alarm1_o   = s.show_al1;
  assign alarm_to_ctrl_o = (|s.alarm) && (s.route == `OSC_ROUTE_CTRL);
  assign alarm_to_aux_o  = (|s.alarm) && (s.route == `OSC_ROUTE_AUX);
  assign irq_o           = |(s.irq_st & s.irq_en);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  chk_linear_frozen: assert property (
    s.lin[0] && !clr_hit[0] && !data_err_i[0] |=> $stable(s.mon[0]))
    else $error("linear output counter moved");

  chk_zero_limit: assert property (
    (s.lim[0] == `OSC_LIM_OFF) [*2] |-> !s.alarm[0])
    else $error("alarm with zero limit");

  chk_mon_range: assert property (
    (s.mon[0] <= `OSC_MON_MAX) && (s.mon[1] <= `OSC_MON_MAX))
    else $error("monitor above full scale");

  chk_alarm_rise: assert property (
    (s.lim[1] != `OSC_LIM_OFF) && (s.mon[1] > s.lim[1]) |=> s.alarm[1])
    else $error("count alarm not raised");

  chk_clear_zero: assert property (
    clr_hit[0] && !data_err_i[0] |=> (s.mon[0] == '0) && !s.err[0] ##1 !s.alarm[0])
    else $error("clear did not zero monitor");

  chk_error_force: assert property (
    data_err_i[1] && (s.lim[1] != `OSC_LIM_OFF) && !wr_i
    |=> (s.mon[1] == `OSC_MON_MAX) ##1 s.alarm[1])
    else $error("data error not forced");

  chk_prescale_range: assert property (
    (s.pre[0] <= `OSC_PRE_LAST) && (s.pre[1] <= `OSC_PRE_LAST))
    else $error("prescaler out of range");

  chk_monitor_hidden: assert property (
    (s.lin == 2'h3) |=> !s.disp.mon_visible)
    else $error("monitor shown for linear outputs");

  chk_d2_priority: assert property (
    sp_hit |=> (s.disp.d2_src == OSC_D2_SPSTAT) && (s.disp.d2_tag == $past(s.sp_sel)))
    else $error("set point tag lost priority");

  chk_heater_hidden: assert property (
    s.disp.d1_phase |-> HAS_HEATER || (s.disp.d1_tag != OSC_TAG_HEATER))
    else $error("heater tag shown without sensing");

endmodule

// >>> rtl/osc_pkg.sv
package osc_pkg;
`include "osc_consts.svh"

  typedef enum logic [3:0] {
    OSC_TAG_OFF     = 4'h0,
    OSC_TAG_MANUAL  = 4'h1,
    OSC_TAG_RESET   = 4'h2,
    OSC_TAG_ALARM1  = 4'h3,
    OSC_TAG_ALARM2  = 4'h4,
    OSC_TAG_ALARM3  = 4'h5,
    OSC_TAG_ANY     = 4'h6,
    OSC_TAG_HEATER  = 4'h7,
    OSC_TAG_STANDBY = 4'h8,
    OSC_TAG_COUNT   = 4'h9,
    OSC_TAG_PEND    = 4'hA,
    OSC_TAG_AT      = 4'hB
  } osc_tag_e;

  typedef enum logic [4:0] {
    OSC_D2_VALUE  = 5'h01,
    OSC_D2_SPSTAT = 5'h02,
    OSC_D2_PEND   = 5'h04,
    OSC_D2_AT     = 5'h08,
    OSC_D2_COUNT  = 5'h10
  } osc_d2_e;

  typedef struct packed {
    logic       manual;
    logic       reset_st;
    logic [2:0] alarm;
    logic       burnout;
    logic       short_al;
    logic       overcur;
    logic       standby;
    logic       prog_end_hold;
    logic       autotune;
  } osc_status_s;

  typedef struct packed {
    logic     d1_phase;
    osc_tag_e d1_tag;
    osc_d2_e  d2_src;
    osc_tag_e d2_tag;
    logic     d2_phase;
    logic     d2_blank;
    logic     mon_visible;
  } osc_disp_s;

  typedef struct packed {
    logic [27:0] rsvd;
    logic [1:0]  route;
    logic [1:0]  linear;
  } osc_ctrl_reg_s;

  typedef struct packed {
    logic [13:0] rsvd;
    logic        err;
    logic        alarm;
    logic [1:0]  pad;
    logic [13:0] count;
  } osc_mon_reg_s;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        visible;
    osc_tag_e    sp_sel;
    osc_tag_e    pv_sel;
  } osc_disp_reg_s;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        showing;
    logic [1:0]  pad;
    logic [4:0]  item;
    logic        mode;
  } osc_fkey_reg_s;

  typedef struct packed {
    logic [1:0]                        sync1;
    logic [1:0]                        sync2;
    logic [1:0]                        sync3;
    logic [1:0]                        level;
    logic [1:0][`OSC_PW-1:0]           pre;
    logic [1:0][`OSC_CW-1:0]           mon;
    logic [1:0][`OSC_CW-1:0]           lim;
    logic [1:0]                        err;
    logic [1:0]                        alarm;
    logic [1:0]                        lin;
    logic [1:0]                        route;
    osc_tag_e                          pv_sel;
    osc_tag_e                          sp_sel;
    logic [`OSC_IRQ_W-1:0]             irq_st;
    logic [`OSC_IRQ_W-1:0]             irq_en;
    logic [`OSC_HW-1:0]                half_cnt;
    logic                              phase;
    logic                              fkey_mode;
    logic [4:0]                        fkey_item;
    logic                              show_al1;
    logic [`OSC_DW-1:0]                rdata;
    osc_disp_s                         disp;
  } osc_state_s;

endpackage
